// File: logic/scesup_defs.svh
// Notes on behaviour
// - At power-up sum program memory, compare with stored checksum; mismatch shows H001, restarts.
// - Write/read every working-memory word, check writes touch one word; failure shows H003.
// - Display holds four dashes while the memory checks run.
// - After memory checks, step display through a test pattern about every half second.
// - Each cycle check all slots for a wrongly placed board; failure shows H004, restarts.
// - An unpermitted display selector code shows H005 and restarts.
// - Each cycle read input board id; no routine for it shows H006, restarts.
// - Input board id differing from the one captured at start shows H003, restarts.
// - Fixed-pH total-chlorine mode with pH displayed flashes the display continuously.
// - In that state suspend calculation, hold total-chlorine output, pH output follows setting.
`ifndef SCESUP_DEFS_SVH
`define SCESUP_DEFS_SVH

// ************************************************************
// Timing
// ************************************************************
`define SCESUP_CLK_MHZ 250
`define SCESUP_STEP_MS 500
`define SCESUP_ERR_MS 2000

// ************************************************************
// Display glyphs and words
// ************************************************************
`define SCESUP_GLYPH_DASH 4'hA
`define SCESUP_GLYPH_H 4'hB
`define SCESUP_DISP_DASHES 16'hAAAA
`define SCESUP_PAT_LAST 4'h9

// ************************************************************
// Error codes shown after the H glyph
// ************************************************************
`define SCESUP_ERR_NONE 12'h000
`define SCESUP_ERR_ROM 12'h001
`define SCESUP_ERR_RAM 12'h003
`define SCESUP_ERR_SLOT 12'h004
`define SCESUP_ERR_DSEL 12'h005
`define SCESUP_ERR_NOID 12'h006

// ************************************************************
// Switch and board codes
// ************************************************************
`define SCESUP_KIND_EMPTY 3'h0
`define SCESUP_KIND_INPUT 3'h1
`define SCESUP_DSEL_PH 2'h1
`define SCESUP_DSEL_PERMIT 4'h7
`define SCESUP_FUNC_FREE_CL 2'h0
`define SCESUP_FUNC_SENSED_PH 2'h1
`define SCESUP_FUNC_FIXED_PH 2'h2
`define SCESUP_ID_SUPPORT 16'h000F
`define SCESUP_SUM_ZERO 16'h0000

`endif

// File: logic/scesup_pkg.sv
package scesup_pkg;

  typedef enum logic [2:0] {
    st_rom_sum,
    st_ram_test,
    st_pattern,
    st_run,
    st_error
  } scesup_state_type;

  typedef enum logic [2:0] {
    rt_idle,
    rt_fill,
    rt_up_read,
    rt_up_check,
    rt_ver_read,
    rt_ver_check,
    rt_done
  } scesup_ram_state_type;

endpackage

// File: logic/scesup_ram_test.sv
`timescale 1ns/10ps
`include "scesup_defs.svh"
module scesup_ram_test import scesup_pkg::*; #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic done,
  output logic fail,
  // Working memory port, one cycle read latency
  output logic [AW-1:0] ram_addr,
  output logic [DW-1:0] ram_wdata,
  output logic ram_we,
  input wire logic [DW-1:0] ram_rdata
);

  typedef struct packed {
    scesup_ram_state_type state;
    logic [AW-1:0] addr;
    logic fail;
  } scesup_rt_type;

  scesup_rt_type s, next_s;
  localparam logic [AW-1:0] LAST = '1;

  // ************************************************************
  // March: zeros up, then read 0 / write 1 up, then read 1 up
  // ************************************************************
  // A write that disturbs a higher word is seen as a non-zero there;
  // one that disturbs a lower word is seen in the final pass.
  always_comb begin
    next_s = s;
    ram_we = 1'b0;
    ram_wdata = '0;
    unique case (s.state)
      rt_idle: begin
        if (start) begin
          next_s.state = rt_fill;
          next_s.addr = '0;
          next_s.fail = 1'b0;
        end
      end
      rt_fill: begin
        ram_we = 1'b1;
        next_s.addr = s.addr + 1'b1;
        if (s.addr == LAST) begin
          next_s.state = rt_up_read;
        end
      end
      rt_up_read: begin
        next_s.state = rt_up_check;
      end
      rt_up_check: begin
        ram_we = 1'b1;
        ram_wdata = '1;
        if (ram_rdata != '0) begin
          next_s.fail = 1'b1;
          next_s.state = rt_done;
        end else if (s.addr == LAST) begin
          next_s.addr = '0;
          next_s.state = rt_ver_read;
        end else begin
          next_s.addr = s.addr + 1'b1;
          next_s.state = rt_up_read;
        end
      end
      rt_ver_read: begin
        next_s.state = rt_ver_check;
      end
      rt_ver_check: begin
        if (ram_rdata != '1) begin
          next_s.fail = 1'b1;
          next_s.state = rt_done;
        end else if (s.addr == LAST) begin
          next_s.state = rt_done;
        end else begin
          next_s.addr = s.addr + 1'b1;
          next_s.state = rt_ver_read;
        end
      end
      rt_done: begin
        next_s.state = rt_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '{state: rt_idle, addr: '0, fail: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign ram_addr = s.addr;
  assign done = (s.state == rt_done);
  assign fail = s.fail;

endmodule

// File: logic/scesup_top.sv
`timescale 1ns/10ps
`include "scesup_defs.svh"
module scesup_top import scesup_pkg::*; #(
  parameter int ROM_AW = 12,
  parameter int RAM_AW = 10,
  parameter int RAM_DW = 8,
  parameter int NSLOT = 4,
  parameter int STEP_CYCLES = `SCESUP_STEP_MS * `SCESUP_CLK_MHZ * 1000,
  parameter int ERR_CYCLES = `SCESUP_ERR_MS * `SCESUP_CLK_MHZ * 1000,
  parameter logic [15:0] ID_SUPPORT = `SCESUP_ID_SUPPORT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Program memory, one cycle read latency
  output logic [ROM_AW-1:0] rom_addr,
  input wire logic [7:0] rom_data,
  input wire logic [15:0] rom_checksum,
  // Working memory
  output logic [RAM_AW-1:0] ram_addr,
  output logic [RAM_DW-1:0] ram_wdata,
  output logic ram_we,
  input wire logic [RAM_DW-1:0] ram_rdata,
  // Pins: slots, selectors, board id (slot 0 is the input board slot)
  input wire logic [NSLOT*3-1:0] slot_kind,
  input wire logic [1:0] disp_sel,
  input wire logic [1:0] func_sel,
  input wire logic [3:0] board_id,
  // Measurement values from the same clock
  input wire logic [15:0] run_digits,
  input wire logic [15:0] tc_in,
  input wire logic [15:0] ph_in,
  input wire logic [15:0] ph_set,
  // Display
  output logic [15:0] disp_digits,
  output logic disp_on,
  // Status and outputs
  output logic [11:0] error_code,
  output logic running,
  output logic calc_enable,
  output logic [15:0] tc_out,
  output logic [15:0] ph_out
);

  localparam int PW = NSLOT * 3 + 8;
  localparam logic [ROM_AW:0] ROM_END = (ROM_AW+1)'(1) << ROM_AW;
  // A literal cannot be bit-selected, so the permit mask needs a name
  localparam logic [3:0] DSEL_PERMIT = `SCESUP_DSEL_PERMIT;

  typedef struct packed {
    scesup_state_type state;
    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    logic [31:0] timer;
    logic [ROM_AW:0] addr;
    logic rd_valid;
    logic [15:0] sum;
    logic [3:0] step;
    logic ram_start;
    logic [3:0] init_id;
    logic [11:0] err;
    logic [15:0] disp;
    logic disp_on;
    logic calc;
    logic [15:0] tc_out;
    logic [15:0] ph_out;
  } scesup_top_type;

  scesup_top_type s, next_s;
  logic rt_done;
  logic rt_fail;
  logic [NSLOT*3-1:0] p_slot;
  logic [1:0] p_dsel;
  logic [1:0] p_func;
  logic [3:0] p_id;
  logic slot_bad;
  logic suspend;

  scesup_ram_test #(
    .AW(RAM_AW),
    .DW(RAM_DW)
  ) u_ram_test (
    .clock(clock),
    .rst(rst),
    .start(s.ram_start),
    .done(rt_done),
    .fail(rt_fail),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata),
    .ram_we(ram_we),
    .ram_rdata(ram_rdata)
  );

  // ************************************************************
  // Synchronised pin fields
  // ************************************************************
  assign {p_slot, p_dsel, p_func, p_id} = s.sync2;
  assign suspend = (p_func == `SCESUP_FUNC_FIXED_PH) && (p_dsel == `SCESUP_DSEL_PH);

  always_comb begin
    slot_bad = 1'b0;
    for (int i = 0; i < NSLOT; i++) begin
      if (i == 0) begin
        if (p_slot[i*3 +: 3] != `SCESUP_KIND_INPUT) begin
          slot_bad = 1'b1;
        end
      end else if (p_slot[i*3 +: 3] == `SCESUP_KIND_INPUT) begin
        slot_bad = 1'b1;
      end
    end
  end

  // ************************************************************
  // Supervisor sequence
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.sync1 = {slot_kind, disp_sel, func_sel, board_id};
    next_s.sync2 = s.sync1;
    next_s.ram_start = 1'b0;
    next_s.timer = s.timer + 32'h0000_0001;
    unique case (s.state)
      st_rom_sum: begin
        next_s.disp = `SCESUP_DISP_DASHES;
        next_s.calc = 1'b0;
        if (s.addr != ROM_END) begin
          next_s.addr = s.addr + 1'b1;
          next_s.rd_valid = 1'b1;
        end else begin
          next_s.rd_valid = 1'b0;
        end
        if (s.rd_valid) begin
          next_s.sum = s.sum + {8'h00, rom_data};
        end
        if (s.addr == ROM_END && !s.rd_valid) begin
          if (s.sum != rom_checksum) begin
            next_s.err = `SCESUP_ERR_ROM;
            next_s.state = st_error;
            next_s.timer = '0;
          end else begin
            next_s.ram_start = 1'b1;
            next_s.state = st_ram_test;
          end
        end
      end
      st_ram_test: begin
        next_s.disp = `SCESUP_DISP_DASHES;
        if (rt_done) begin
          next_s.timer = '0;
          next_s.step = '0;
          if (rt_fail) begin
            next_s.err = `SCESUP_ERR_RAM;
            next_s.state = st_error;
          end else begin
            next_s.state = st_pattern;
          end
        end
      end
      st_pattern: begin
        next_s.disp = {4{s.step}};
        if (s.timer >= 32'(STEP_CYCLES - 1)) begin
          next_s.timer = '0;
          if (s.step == `SCESUP_PAT_LAST) begin
            // Board id is caught here, as the reference for every cycle
            next_s.init_id = p_id;
            next_s.state = st_run;
          end else begin
            next_s.step = s.step + 4'h1;
          end
        end
      end
      st_run: begin
        next_s.disp = run_digits;
        next_s.calc = !suspend;
        if (suspend) begin
          next_s.ph_out = ph_set;
          if (s.timer >= 32'(STEP_CYCLES - 1)) begin
            next_s.timer = '0;
            next_s.disp_on = !s.disp_on;
          end
        end else begin
          next_s.disp_on = 1'b1;
          next_s.ph_out = ph_in;
          next_s.tc_out = tc_in;
        end
        // Priority when several faults coincide: slot, selector, id
        if (slot_bad) begin
          next_s.err = `SCESUP_ERR_SLOT;
        end else if (!DSEL_PERMIT[p_dsel]) begin
          next_s.err = `SCESUP_ERR_DSEL;
        end else if (!ID_SUPPORT[p_id]) begin
          next_s.err = `SCESUP_ERR_NOID;
        end else if (p_id != s.init_id) begin
          next_s.err = `SCESUP_ERR_RAM;
        end
        if (slot_bad || !DSEL_PERMIT[p_dsel] || !ID_SUPPORT[p_id]
            || p_id != s.init_id) begin
          next_s.state = st_error;
          // Show the code at once; a stale run reading must not linger
          next_s.disp = {`SCESUP_GLYPH_H, next_s.err};
          next_s.timer = '0;
          next_s.calc = 1'b0;
          next_s.disp_on = 1'b1;
        end
      end
      st_error: begin
        next_s.disp = {`SCESUP_GLYPH_H, s.err};
        // Error stays visible long enough to be read before the restart
        if (s.timer >= 32'(ERR_CYCLES - 1)) begin
          next_s.state = st_rom_sum;
          next_s.disp = `SCESUP_DISP_DASHES;
          next_s.addr = '0;
          next_s.rd_valid = 1'b0;
          next_s.sum = `SCESUP_SUM_ZERO;
          next_s.err = `SCESUP_ERR_NONE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '{state: st_rom_sum, sync1: '0, sync2: '0, timer: '0, addr: '0,
             rd_valid: 1'b0, sum: `SCESUP_SUM_ZERO, step: '0, ram_start: 1'b0,
             init_id: '0, err: `SCESUP_ERR_NONE, disp: `SCESUP_DISP_DASHES,
             disp_on: 1'b1, calc: 1'b0, tc_out: '0, ph_out: '0};
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rom_addr = s.addr[ROM_AW-1:0];
  assign disp_digits = s.disp;
  assign disp_on = s.disp_on;
  assign error_code = s.err;
  assign running = (s.state == st_run);
  assign calc_enable = s.calc;
  assign tc_out = s.tc_out;
  assign ph_out = s.ph_out;

endmodule

// File: testbench/scesup_checker.sv
`timescale 1ns/10ps
`include "scesup_defs.svh"
module scesup_checker import scesup_pkg::*; #(
  parameter int ROM_AW = 12,
  parameter int NSLOT = 4,
  parameter logic [15:0] ID_SUPPORT = `SCESUP_ID_SUPPORT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Memories and pins
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic ram_we,
  input wire logic [NSLOT*3-1:0] slot_kind,
  input wire logic [1:0] disp_sel,
  input wire logic [1:0] func_sel,
  input wire logic [3:0] board_id,
  input wire logic [15:0] ph_set,
  input wire logic [15:0] tc_in,
  // Results
  input wire logic [15:0] disp_digits,
  input wire logic disp_on,
  input wire logic [11:0] error_code,
  input wire logic running,
  input wire logic calc_enable,
  input wire logic [15:0] tc_out,
  input wire logic [15:0] ph_out
);
  logic slot_bad;
  logic is_err;
  assign is_err = disp_digits[15:12] == `SCESUP_GLYPH_H;
  always_comb begin
    slot_bad = slot_kind[2:0] != `SCESUP_KIND_INPUT;
    for (int i = 1; i < NSLOT; i++) begin
      if (slot_kind[i*3+:3] == `SCESUP_KIND_INPUT) begin
        slot_bad = 1'b1;
      end
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence rom_start;
    rom_addr == '0 && disp_digits == `SCESUP_DISP_DASHES ##1 rom_addr == 1;
  endsequence
  // Pins settle through two flops, so faults need a few cycles to land
  sequence suspended;
    (running && func_sel == `SCESUP_FUNC_FIXED_PH && disp_sel == `SCESUP_DSEL_PH)[*5];
  endsequence
  chk_rom_start: assert property ($fell(rst) |-> rom_start)
    else $error("rom walk");
  chk_mem_dashes: assert property (ram_we |-> disp_digits == `SCESUP_DISP_DASHES)
    else $error("no dashes");
  chk_pattern_form: assert property (!running && disp_digits[15:12] < 4'ha
    |-> disp_digits == {4{disp_digits[3:0]}}) else $error("pattern");
  chk_slot_fault: assert property (running && slot_bad
    |-> ##[1:4] disp_digits == {`SCESUP_GLYPH_H, `SCESUP_ERR_SLOT}) else $error("slot");
  chk_sel_fault: assert property (running && !slot_bad && disp_sel == 2'h3
    |-> ##[1:4] disp_digits == {`SCESUP_GLYPH_H, `SCESUP_ERR_DSEL}) else $error("sel");
  chk_id_fault: assert property (running && !slot_bad && disp_sel != 2'h3
    && !ID_SUPPORT[board_id] |-> ##[1:4] disp_digits == {`SCESUP_GLYPH_H, `SCESUP_ERR_NOID})
    else $error("id");
  chk_err_code: assert property (is_err && $past(is_err)
    |-> disp_digits[11:0] == error_code) else $error("code");
  chk_flash_cause: assert property ($fell(disp_on)
    |-> running && $past(func_sel, 3) == `SCESUP_FUNC_FIXED_PH
    && $past(disp_sel, 3) == `SCESUP_DSEL_PH)
    else $error("flash");
  chk_hold_outs: assert property (suspended
    |-> !calc_enable && ph_out == $past(ph_set)) else $error("suspend");
  chk_tc_hold: assert property (suspended |-> tc_out == $past(tc_out))
    else $error("tc hold");
  chk_tc_track: assert property ($past(running)
    && !($past(func_sel, 3) == `SCESUP_FUNC_FIXED_PH && $past(disp_sel, 3) == `SCESUP_DSEL_PH)
    |-> tc_out == $past(tc_in)) else $error("tc track");
  chk_err_restart: assert property ($fell(is_err)
    |-> disp_digits == `SCESUP_DISP_DASHES && rom_addr == '0) else $error("restart");
endmodule
bind scesup_top scesup_checker #(.ROM_AW(ROM_AW), .NSLOT(NSLOT), .ID_SUPPORT(ID_SUPPORT))
  u_chk (.*);

// File: testbench/scesup_mem_model.sv
`timescale 1ns/10ps
module scesup_mem_model #(
  parameter int ROM_AW = 4,
  parameter int RAM_AW = 3
) (
  // Clock
  input wire logic clock,
  // Memories
  input wire logic [ROM_AW-1:0] rom_addr,
  output logic [7:0] rom_data,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  output logic [7:0] ram_rdata,
  // Fault control
  input wire logic stuck
);
  logic [7:0] rom [2**ROM_AW];
  logic [7:0] ram [2**RAM_AW];
  initial begin
    for (int i = 0; i < 2**ROM_AW; i++) begin
      rom[i] = 8'(i * 37 + 11);
    end
  end
  // Dead cell: bit 0 of word 5 reads low while stuck
  always_ff @(posedge clock) begin
    rom_data <= rom[rom_addr];
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
    ram_rdata <= ram[ram_addr] & ~{7'h00, stuck && ram_addr == 3'h5};
  end
endmodule

// File: testbench/test_self_check_error_supervisor.sv
`timescale 1ns/10ps
`include "scesup_defs.svh"
module test_self_check_error_supervisor;
  import scesup_pkg::*;
  logic clock, rst, ram_we, disp_on, running, calc_enable, stuck;
  logic [3:0] rom_addr, board_id;
  logic [7:0] rom_data, ram_wdata, ram_rdata;
  logic [2:0] ram_addr;
  logic [11:0] slot_kind, error_code;
  logic [1:0] disp_sel, func_sel;
  logic [15:0] rom_checksum, run_digits, tc_in, ph_in, ph_set, disp_digits, tc_out, ph_out;
  logic [15:0] sum;
  logic [19:0] exp_q[$];
  logic prev_h = 1'b0, prev_run = 1'b0, prev_on = 1'b1;
  int err_count = 0, compares = 0;
  wire is_h = disp_digits[15:12] == `SCESUP_GLYPH_H;
  scesup_top #(.ROM_AW(4), .RAM_AW(3), .STEP_CYCLES(8), .ERR_CYCLES(16)) u_dut (.*);
  scesup_mem_model #(.ROM_AW(4), .RAM_AW(3)) u_mem (.*);
  // ********
  // Tasks
  // ********
  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // An event with nothing queued is always wrong
  task automatic take(input logic [19:0] seen);
    if (exp_q.size() == 0) check(seen, 20'hf_ffff);
    else check(seen, exp_q.pop_front());
  endtask
  task automatic wait_notes();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (exp_q.size() != 0) begin
      err_count++;
      exp_q.delete();
    end
  endtask
  task automatic fault(input logic [11:0] code);
    exp_q.push_back({4'h1, `SCESUP_GLYPH_H, code});
    wait_notes();
  endtask
  task automatic back_to_run();
    exp_q.push_back({4'h2, 16'h0000});
    wait_notes();
  endtask
  // ********
  // Monitor and clock
  // ********
  always @(posedge clock) begin
    if (!rst && is_h && !prev_h) take({4'h1, disp_digits});
    if (!rst && running && !prev_run) take({4'h2, 16'h0000});
    if (!rst && running && !disp_on && prev_on) take({4'h3, ph_out});
    prev_h <= is_h;
    prev_run <= running;
    prev_on <= disp_on;
  end
  // Measurements move every cycle; top digit kept off the dash and H glyphs
  always @(posedge clock) begin
    run_digits <= {4'($urandom % 10), 12'($urandom)};
    tc_in <= 16'($urandom);
    ph_in <= 16'($urandom);
  end
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Whole run is near 1400 cycles; allow far more
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  // ********
  // Scenarios
  // ********
  initial begin
    void'($urandom(5));
    rst = 1'b1;
    stuck = 1'b0;
    slot_kind = 12'h001;
    disp_sel = 2'h0;
    func_sel = 2'h0;
    board_id = 4'h1;
    rom_checksum = 16'h0000;
    ph_set = 16'($urandom());
    repeat (3) @(posedge clock);
    sum = 16'h0000;
    for (int i = 0; i < 16; i++) sum += 16'(u_mem.rom[i]);
    rom_checksum <= sum ^ 16'h0100;
    rst <= 1'b0;
    fault(`SCESUP_ERR_ROM);
    fault(`SCESUP_ERR_ROM);
    rom_checksum <= sum;
    back_to_run();
    rst <= 1'b1;
    stuck <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    fault(`SCESUP_ERR_RAM);
    stuck <= 1'b0;
    back_to_run();
    for (int k = 0; k < 2; k++) begin
      slot_kind <= k == 0 ? 12'h000 : 12'h001 | 12'(12'h001 << (3 + 3 * ($urandom % 3)));
      fault(`SCESUP_ERR_SLOT);
      slot_kind <= 12'h001;
      back_to_run();
    end
    disp_sel <= 2'h3;
    fault(`SCESUP_ERR_DSEL);
    disp_sel <= 2'h0;
    back_to_run();
    board_id <= 4'h4 + 4'($urandom % 12);
    fault(`SCESUP_ERR_NOID);
    board_id <= 4'h1;
    back_to_run();
    board_id <= 4'h2 + 4'($urandom % 2);
    fault(`SCESUP_ERR_RAM);
    back_to_run();
    for (int f = 0; f < 3; f++) begin
      for (int d = 0; d < 3; d++) begin
        func_sel <= 2'(f);
        disp_sel <= 2'(d);
        if (f == 2 && d == 1) begin
          exp_q.push_back({4'h3, ph_set});
          exp_q.push_back({4'h3, ph_set});
          wait_notes();
        end
        else repeat (20) @(posedge clock);
      end
    end
    report_and_stop();
  end
endmodule
